// [design/mb_map.svh]
// Constants for the register-protocol command handler.
// Function
// - Accept only read 3 and write 16
// - Serial requests start with matching slave address
// - Start register equals list number times 2 plus 256
// - Read asks 2 to 124 registers
// - Read returns consecutive values from start index
// - Value byte order follows endian setting
// - Serial frames end with CRC, high first
// - Read reply: address, 3, count, data, CRC
// - Read data holds 4 to 248 bytes
// - Only write target is 426 count 2
// - Written value 0..3 selects operating mode
// - Write reply echoes first six request bytes
// - Error reply: address, code plus 128, exception, CRC
// - Exception codes are 1, 2, 3, 4
`ifndef MB_MAP_SVH
`define MB_MAP_SVH
`define FC_READ 8'h03
`define FC_WRITE 8'h10
`define EXC_FLAG 8'h80
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03
`define EXC_FAIL 8'h04
`define REG_BASE 16'h0100
`define WR_REG 16'h01AA
`define RD_MIN 16'h0002
`define RD_MAX 16'h007C
`define WR_COUNT 16'h0002
`define WR_BYTES 8'h04
`define VAL_MEASURE 32'h0000_0000
`define VAL_CYCLE 32'h3F80_0000
`define VAL_ZERO 32'h4000_0000
`define VAL_SPAN 32'h4040_0000
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define RD_LEN 8'h06
`define WR_LEN 8'h0B
`define RD_HDR 8'h04
`define WR_ECHO 8'h06
`define ERR_LEN 8'h03
`define FRAME_DEPTH 13
`endif

// [design/mb_pkg.sv]
// Types shared by the command handler modules.
package mb_pkg;
  // Main sequencer states.
  typedef enum logic [1:0] {
    ST_RX = 2'b00,
    ST_DECODE = 2'b01,
    ST_LOAD = 2'b10,
    ST_TX = 2'b11
  } state_t;
  // Kind of reply being sent.
  typedef enum logic [1:0] {
    RESP_READ = 2'b00,
    RESP_WRITE = 2'b01,
    RESP_ERROR = 2'b10
  } resp_t;
  // Instrument operating modes selected by the write command.
  typedef enum logic [1:0] {
    MODE_MEASURE = 2'b00,
    MODE_CYCLE = 2'b01,
    MODE_ZERO = 2'b10,
    MODE_SPAN = 2'b11
  } mode_t;
endpackage

// [design/crc_if.sv]
// Interface between the sequencer and a CRC accumulator.
`timescale 1ns/1ns
interface crc_if;
  logic clear; // Restart the checksum.
  logic step; // Fold data into the checksum.
  logic [7:0] data; // Byte to fold in.
  logic [15:0] crc; // Current checksum.
  logic [15:0] crc_next; // Checksum after folding data in.
  modport user (output clear, output step, output data, input crc, input crc_next);
  modport unit (input clear, input step, input data, output crc, output crc_next);
endinterface

// [design/crc_unit.sv]
// Bytewise CRC-16 accumulator with the reflected 0xA001 polynomial.
`timescale 1ns/1ns
`include "mb_map.svh"
module crc_unit (
  input wire logic clock_in,
  input wire logic srst_in,
  crc_if.unit port
);
  logic [15:0] crc_q; // Running checksum.
  logic [15:0] crc_d; // Next checksum.

  // Folds one byte into a checksum, low bit first.
  function automatic logic [15:0] crc_fold(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Chooses between restart, fold and hold.
  always_comb begin
    crc_d = crc_q;
    if (port.clear) begin
      crc_d = `CRC_INIT;
    end else if (port.step) begin
      crc_d = crc_fold(crc_q, port.data);
    end
  end

  // Registers the checksum.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      crc_q <= `CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign port.crc = crc_q;
  assign port.crc_next = crc_fold(crc_q, port.data);
endmodule

// [design/modbus_slave_command_handler.sv]
// Register-protocol request decoder and reply generator.
`timescale 1ns/1ns
`include "mb_map.svh"
module modbus_slave_command_handler #(
  parameter logic [15:0] NUM_PARAMS = 16'h0100
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic serial_link_in,
  input wire logic [7:0] slave_id_in,
  input wire logic big_endian_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  input wire logic rx_last_in,
  output logic rx_ready_out,
  output logic [7:0] tx_byte_out,
  output logic tx_valid_out,
  output logic tx_last_out,
  input wire logic tx_ready_in,
  output logic [15:0] param_index_out,
  input wire logic [31:0] param_value_in,
  input wire logic mode_busy_in,
  output logic [1:0] mode_out,
  output logic mode_strobe_out,
  output logic discard_out
);
  crc_if rx_crc(); // Checksum of incoming bytes.
  crc_if tx_crc(); // Checksum of outgoing bytes.
  crc_unit rx_crc_unit (.clock_in(clock_in), .srst_in(srst_in), .port(rx_crc));
  crc_unit tx_crc_unit (.clock_in(clock_in), .srst_in(srst_in), .port(tx_crc));

  mb_pkg::state_t state_q, state_d; // Sequencer state.
  mb_pkg::resp_t resp_q, resp_d; // Reply kind.
  logic [7:0] frame_q [`FRAME_DEPTH]; // Request bytes at logical positions.
  logic [7:0] frame_d [`FRAME_DEPTH];
  logic [7:0] pos_q, pos_d; // Bytes received, or logical reply position.
  logic ovf_q, ovf_d; // Request longer than any legal frame.
  logic [15:0] prev1_q, prev1_d; // Checksum before the newest byte.
  logic [15:0] prev2_q, prev2_d; // Checksum before the newest two bytes.
  logic [7:0] exc_q, exc_d; // Exception code of an error reply.
  logic [7:0] dend_q, dend_d; // First checksum position of the reply.
  logic [7:0] last_q, last_d; // Final position of the reply.
  logic [15:0] base_q, base_d; // First parameter index of a read.
  logic [7:0] txb_q, txb_d; // Byte on the transmit port.
  logic txv_q, txv_d; // Transmit byte valid.
  logic txl_q, txl_d; // Transmit byte is the last.
  logic [1:0] mode_q, mode_d; // Selected operating mode.
  logic strobe_q, strobe_d; // Mode change pulse.
  logic drop_q, drop_d; // Discard pulse.
  logic [7:0] ld_pos; // Reply position being loaded.
  logic [7:0] ld_byte; // Reply byte at that position.
  logic [7:0] lpos; // Logical length of the request.
  logic [7:0] off; // Logical position of the first received byte.
  logic [15:0] start_reg; // Requested start register.
  logic [15:0] reg_count; // Requested register count.
  logic [31:0] wr_value; // Written value in natural order.
  logic [7:0] dsel; // Offset into the read data field.
  logic tx_take; // A reply byte is taken this cycle.

  // Picks one byte of a value honouring the endian setting.
  function automatic logic [7:0] value_byte(input logic [31:0] v, input logic [1:0] s,
                                            input logic big);
    logic [1:0] k;
    k = big ? s : 2'(2'd3 - s);
    return v[8*k +: 8];
  endfunction

  assign off = serial_link_in ? 8'h00 : 8'h01;
  assign lpos = 8'(pos_q + off);
  assign start_reg = {frame_q[2], frame_q[3]};
  assign reg_count = {frame_q[4], frame_q[5]};
  assign wr_value = big_endian_in ? {frame_q[10], frame_q[9], frame_q[8], frame_q[7]}
                                  : {frame_q[7], frame_q[8], frame_q[9], frame_q[10]};
  assign tx_take = (state_q == mb_pkg::ST_TX) && txv_q && tx_ready_in;
  assign ld_pos = (state_q == mb_pkg::ST_LOAD) ? pos_q : 8'(pos_q + 8'h01);
  assign dsel = 8'(ld_pos - `RD_HDR);
  assign param_index_out = 16'(base_q + {10'h000, dsel[7:2]});

  // Computes the reply byte at the position about to be loaded.
  always_comb begin
    ld_byte = 8'h00;
    if (serial_link_in && ld_pos == dend_q) begin
      ld_byte = tx_crc.crc_next[15:8];
    end else if (serial_link_in && ld_pos > dend_q) begin
      ld_byte = tx_crc.crc[7:0];
    end else if (ld_pos == 8'h00) begin
      ld_byte = slave_id_in;
    end else begin
      unique case (resp_q)
        mb_pkg::RESP_READ: begin
          if (ld_pos == 8'h01) begin
            ld_byte = `FC_READ;
          end else if (ld_pos < `RD_HDR) begin
            // The echoed register count sits two positions after the start register.
            ld_byte = frame_q[4'(ld_pos + 8'h02)];
          end else begin
            ld_byte = value_byte(param_value_in, dsel[1:0], big_endian_in);
          end
        end
        mb_pkg::RESP_WRITE: begin
          ld_byte = frame_q[ld_pos[3:0]];
        end
        default: begin
          ld_byte = (ld_pos == 8'h01) ? (frame_q[1] | `EXC_FLAG) : exc_q;
        end
      endcase
    end
  end

  // Drives both checksum units.
  always_comb begin
    rx_crc.clear = (state_q == mb_pkg::ST_DECODE);
    rx_crc.step = (state_q == mb_pkg::ST_RX) && rx_valid_in;
    rx_crc.data = rx_byte_in;
    tx_crc.clear = (state_q == mb_pkg::ST_DECODE);
    tx_crc.step = tx_take && (pos_q < dend_q);
    tx_crc.data = txb_q;
  end

  // Sequencer: collects a request, judges it, then streams the reply.
  always_comb begin
    state_d = state_q;
    resp_d = resp_q;
    frame_d = frame_q;
    pos_d = pos_q;
    ovf_d = ovf_q;
    prev1_d = prev1_q;
    prev2_d = prev2_q;
    exc_d = exc_q;
    dend_d = dend_q;
    last_d = last_q;
    base_d = base_q;
    txb_d = txb_q;
    txv_d = txv_q;
    txl_d = txl_q;
    mode_d = mode_q;
    strobe_d = 1'b0;
    drop_d = 1'b0;
    unique case (state_q)
      mb_pkg::ST_RX: begin
        if (rx_valid_in) begin
          if (lpos < 8'(`FRAME_DEPTH)) begin
            frame_d[lpos[3:0]] = rx_byte_in;
            pos_d = 8'(pos_q + 8'h01);
          end else begin
            ovf_d = 1'b1;
          end
          prev1_d = rx_crc.crc;
          prev2_d = prev1_q;
          if (rx_last_in) begin
            state_d = mb_pkg::ST_DECODE;
          end
        end
      end
      mb_pkg::ST_DECODE: begin
        state_d = mb_pkg::ST_LOAD;
        resp_d = mb_pkg::RESP_ERROR;
        exc_d = 8'h00;
        base_d = 16'((start_reg - `REG_BASE) >> 1);
        if (ovf_q || lpos < 8'h02 || (serial_link_in && (pos_q < 8'h04
            || frame_q[0] != slave_id_in
            || prev2_q != {frame_q[4'(lpos - 8'h02)], frame_q[4'(lpos - 8'h01)]}))) begin
          drop_d = 1'b1;
          state_d = mb_pkg::ST_RX;
        end else if (frame_q[1] == `FC_READ) begin
          if (8'(lpos - (serial_link_in ? 8'h02 : 8'h00)) != `RD_LEN || reg_count[0]
              || reg_count < `RD_MIN || reg_count > `RD_MAX) begin
            exc_d = `EXC_VALUE;
          end else if (start_reg < `REG_BASE || start_reg[0]
              || 17'(base_d) + 17'(reg_count >> 1) > 17'(NUM_PARAMS)) begin
            exc_d = `EXC_ADDR;
          end else begin
            resp_d = mb_pkg::RESP_READ;
          end
        end else if (frame_q[1] == `FC_WRITE) begin
          if (start_reg != `WR_REG) begin
            exc_d = `EXC_ADDR;
          end else if (8'(lpos - (serial_link_in ? 8'h02 : 8'h00)) != `WR_LEN
              || reg_count != `WR_COUNT || frame_q[6] != `WR_BYTES) begin
            exc_d = `EXC_VALUE;
          end else if (wr_value != `VAL_MEASURE && wr_value != `VAL_CYCLE
              && wr_value != `VAL_ZERO && wr_value != `VAL_SPAN) begin
            exc_d = `EXC_VALUE;
          end else if (mode_busy_in) begin
            exc_d = `EXC_FAIL;
          end else begin
            resp_d = mb_pkg::RESP_WRITE;
            strobe_d = 1'b1;
            // Decode the accepted value into a mode.
            if (wr_value == `VAL_CYCLE) begin
              mode_d = mb_pkg::MODE_CYCLE;
            end else if (wr_value == `VAL_ZERO) begin
              mode_d = mb_pkg::MODE_ZERO;
            end else if (wr_value == `VAL_SPAN) begin
              mode_d = mb_pkg::MODE_SPAN;
            end else begin
              mode_d = mb_pkg::MODE_MEASURE;
            end
          end
        end else begin
          exc_d = `EXC_FUNC;
        end
        // Reply length: data part, then two checksum bytes on serial links.
        if (resp_d == mb_pkg::RESP_READ) begin
          dend_d = 8'(`RD_HDR + {reg_count[6:0], 1'b0});
        end else if (resp_d == mb_pkg::RESP_WRITE) begin
          dend_d = `WR_ECHO;
        end else begin
          dend_d = `ERR_LEN;
        end
        last_d = serial_link_in ? 8'(dend_d + 8'h01) : 8'(dend_d - 8'h01);
        pos_d = off;
      end
      mb_pkg::ST_LOAD: begin
        txb_d = ld_byte;
        txv_d = 1'b1;
        txl_d = (pos_q == last_q);
        state_d = mb_pkg::ST_TX;
      end
      mb_pkg::ST_TX: begin
        if (tx_take) begin
          if (txl_q) begin
            txv_d = 1'b0;
            txl_d = 1'b0;
            pos_d = 8'h00;
            ovf_d = 1'b0;
            state_d = mb_pkg::ST_RX;
          end else begin
            txb_d = ld_byte;
            txl_d = (ld_pos == last_q);
            pos_d = ld_pos;
          end
        end
      end
    endcase
    if (drop_d) begin
      pos_d = 8'h00;
      ovf_d = 1'b0;
    end
  end

  // Registers the sequencer state.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_q <= mb_pkg::ST_RX;
      resp_q <= mb_pkg::RESP_ERROR;
      for (int i = 0; i < `FRAME_DEPTH; i++) begin
        frame_q[i] <= 8'h00;
      end
      pos_q <= 8'h00;
      ovf_q <= 1'b0;
      prev1_q <= `CRC_INIT;
      prev2_q <= `CRC_INIT;
      exc_q <= 8'h00;
      dend_q <= 8'h00;
      last_q <= 8'h00;
      base_q <= 16'h0000;
      txb_q <= 8'h00;
      txv_q <= 1'b0;
      txl_q <= 1'b0;
      mode_q <= mb_pkg::MODE_MEASURE;
      strobe_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      state_q <= state_d;
      resp_q <= resp_d;
      frame_q <= frame_d;
      pos_q <= pos_d;
      ovf_q <= ovf_d;
      prev1_q <= prev1_d;
      prev2_q <= prev2_d;
      exc_q <= exc_d;
      dend_q <= dend_d;
      last_q <= last_d;
      base_q <= base_d;
      txb_q <= txb_d;
      txv_q <= txv_d;
      txl_q <= txl_d;
      mode_q <= mode_d;
      strobe_q <= strobe_d;
      drop_q <= drop_d;
    end
  end

  assign rx_ready_out = (state_q == mb_pkg::ST_RX);
  assign tx_byte_out = txb_q;
  assign tx_valid_out = txv_q;
  assign tx_last_out = txl_q;
  assign mode_out = mode_q;
  assign mode_strobe_out = strobe_q;
  assign discard_out = drop_q;
endmodule

// [sim/mb_properties.sv]
// Concurrent checks on the command handler ports.
`timescale 1ns/1ns
module mb_properties (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic serial_link_in,
  input wire logic [7:0] slave_id_in,
  input wire logic rx_valid_in,
  input wire logic rx_last_in,
  input wire logic rx_ready_out,
  input wire logic [7:0] tx_byte_out,
  input wire logic tx_valid_out,
  input wire logic tx_last_out,
  input wire logic tx_ready_in,
  input wire logic [1:0] mode_out,
  input wire logic mode_strobe_out,
  input wire logic discard_out
);
  logic [7:0] pos_q, pos_d, fc_q, fc_d; // Reply byte index and reply code byte.
  logic [7:0] fcp; // Index of the code byte in a reply.
  assign fcp = {7'h00, serial_link_in};
  // Track the reply position and remember the code byte.
  always_comb begin
    pos_d = pos_q;
    fc_d = fc_q;
    if (tx_valid_out && tx_ready_in) begin
      pos_d = tx_last_out ? 8'h00 : pos_q + 8'h01;
      if (pos_q == fcp) fc_d = tx_byte_out;
    end
  end
  always_ff @(posedge clock_in) begin
    pos_q <= srst_in ? 8'h00 : pos_d;
    fc_q <= srst_in ? 8'h00 : fc_d;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  hold_byte_a: assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out) && $stable(tx_last_out))
    else $error("reply byte changed before it was taken");
  addr_first_a: assert property (
    $rose(tx_valid_out) && serial_link_in |-> tx_byte_out == slave_id_in)
    else $error("reply does not open with the slave address");
  func_code_a: assert property (
    tx_valid_out && pos_q == fcp |-> tx_byte_out inside {8'h03, 8'h10} || tx_byte_out[7])
    else $error("reply code is neither a supported code nor an error code");
  exc_code_a: assert property (
    tx_valid_out && fc_q[7] && pos_q == fcp + 8'h01 |-> tx_byte_out inside {[8'h01:8'h04]})
    else $error("exception code out of range");
  err_len_a: assert property (
    tx_valid_out && tx_last_out && fc_q[7] |-> pos_q == (serial_link_in ? 8'h04 : 8'h01))
    else $error("error reply has wrong length");
  echo_len_a: assert property (
    tx_valid_out && tx_last_out && fc_q == 8'h10 |-> pos_q == (serial_link_in ? 8'h07 : 8'h04))
    else $error("write echo has wrong length");
  mode_change_a: assert property (
    $changed(mode_out) |-> mode_strobe_out)
    else $error("mode changed without a strobe");
  strobe_reply_a: assert property (
    mode_strobe_out |-> ##[0:3] (tx_valid_out && !rx_ready_out))
    else $error("accepted write not answered");
  drop_quiet_a: assert property (
    discard_out |-> !tx_valid_out ##1 !tx_valid_out)
    else $error("dropped request produced a reply");
  turn_around_a: assert property (
    rx_valid_in && rx_ready_out && rx_last_in |=> !rx_ready_out ##[1:3] (tx_valid_out || discard_out))
    else $error("request neither answered nor dropped");
  cover property (discard_out);
  cover property (mode_strobe_out);
  cover property (tx_valid_out && tx_last_out && fc_q[7]);
endmodule
bind modbus_slave_command_handler mb_properties u_mb_properties (.clock_in, .srst_in,
  .serial_link_in, .slave_id_in, .rx_valid_in, .rx_last_in, .rx_ready_out, .tx_byte_out,
  .tx_valid_out, .tx_last_out, .tx_ready_in, .mode_out, .mode_strobe_out, .discard_out);

// [sim/mb_master.sv]
// Bus master model: offers requests and sinks replies.
`timescale 1ns/1ns
module mb_master (
  input wire logic clock_in,
  input wire logic rx_ready_out,
  input wire logic stall_in,
  output logic [7:0] rx_byte_in,
  output logic rx_valid_in,
  output logic rx_last_in,
  output logic tx_ready_in,
  output logic fail_out
);
  initial begin
    rx_byte_in = 8'h00;
    rx_valid_in = 1'b0;
    rx_last_in = 1'b0;
    tx_ready_in = 1'b1;
    fail_out = 1'b0;
  end
  // The sink takes every byte, or only now and then when stalling.
  always @(negedge clock_in) begin
    tx_ready_in <= !stall_in || ($urandom_range(0, 2) == 0);
  end
  // Each byte stands until the handler takes it; the line is scrambled after the last one.
  task automatic send(input logic [7:0] req[$]);
    int n;
    foreach (req[i]) begin
      @(negedge clock_in);
      rx_byte_in = req[i];
      rx_valid_in = 1'b1;
      rx_last_in = (i == req.size() - 1);
      n = 0;
      while (!rx_ready_out && n < 300) begin
        @(negedge clock_in);
        n++;
      end
      if (n == 300) fail_out = 1'b1;
      @(posedge clock_in);
    end
    @(negedge clock_in);
    rx_valid_in = 1'b0;
    rx_last_in = 1'b0;
    rx_byte_in = ~rx_byte_in;
  endtask
endmodule

// [sim/testbench.sv]
// Self-checking bench for the command handler.
`timescale 1ns/1ns
`include "mb_map.svh"
module testbench;
  logic clock_in, srst_in, serial_link_in, big_endian_in, mode_busy_in, stall, fail;
  logic [7:0] slave_id_in, rx_byte_in, tx_byte_out;
  logic rx_valid_in, rx_last_in, rx_ready_out, tx_valid_out, tx_last_out, tx_ready_in;
  logic [15:0] param_index_out;
  logic [31:0] param_value_in;
  logic [1:0] mode_out;
  logic mode_strobe_out, discard_out;
  logic [7:0] exp_q[$]; // Expected reply bytes.
  int len_q[$]; // Expected reply lengths; zero means dropped.
  logic [1:0] mode_q[$]; // Expected modes.
  logic [31:0] vals[4] = '{`VAL_MEASURE, `VAL_CYCLE, `VAL_ZERO, `VAL_SPAN};
  int mismatches, checked, pos, r;
  modbus_slave_command_handler #(.NUM_PARAMS(16'h0040)) u_modbus_slave_command_handler (
    .clock_in, .srst_in, .serial_link_in, .slave_id_in, .big_endian_in, .rx_byte_in,
    .rx_valid_in, .rx_last_in, .rx_ready_out, .tx_byte_out, .tx_valid_out, .tx_last_out,
    .tx_ready_in, .param_index_out, .param_value_in, .mode_busy_in, .mode_out,
    .mode_strobe_out, .discard_out);
  mb_master u_mb_master (.clock_in, .rx_ready_out, .stall_in(stall), .rx_byte_in,
    .rx_valid_in, .rx_last_in, .tx_ready_in, .fail_out(fail));
  // Parameter table: a distinct value for every index.
  function automatic logic [31:0] pv(input logic [15:0] i);
    return {i ^ 16'hC35A, i};
  endfunction
  assign param_value_in = pv(param_index_out);
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // Appends a value in the selected byte order.
  task automatic put(ref logic [7:0] q[$], input logic [31:0] v);
    for (int k = 0; k < 4; k++) q.push_back(big_endian_in ? v[8*k +: 8] : v[31-8*k -: 8]);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (fail !== 1'b0) mismatches++;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Sends one request and notes its reply; bad 1 spoils the address, 2 the checksum.
  task automatic run(input logic [7:0] fc, input logic [15:0] st, input logic [15:0] cnt,
                     input logic [31:0] wv, input logic [7:0] exc, input int bad);
    logic [7:0] rq[$];
    logic [7:0] rs[$];
    logic [15:0] c;
    int n;
    if (serial_link_in) rq.push_back(slave_id_in ^ {7'h00, bad == 1});
    rq = {rq, fc, st[15:8], st[7:0], cnt[15:8], cnt[7:0]};
    if (fc == `FC_WRITE) rq.push_back(`WR_BYTES);
    if (fc == `FC_WRITE) put(rq, wv);
    c = crc(rq) ^ {15'h0000, bad == 2};
    if (serial_link_in) rq = {rq, c[15:8], c[7:0]};
    if (serial_link_in) rs.push_back(slave_id_in);
    if (exc != 0) rs = {rs, fc | `EXC_FLAG, exc};
    else if (fc == `FC_READ) begin
      rs = {rs, fc, cnt[15:8], cnt[7:0]};
      for (int i = 0; i < cnt / 2; i++) put(rs, pv(16'((st - 16'h0100) / 2 + i)));
    end else begin
      rs = rq[0:(serial_link_in ? 5 : 4)];
      // A dropped write changes no mode, so it leaves no note.
      if (bad == 0) mode_q.push_back(wv == `VAL_CYCLE ? 2'h1 : wv == `VAL_ZERO ? 2'h2 :
                                     wv == `VAL_SPAN ? 2'h3 : 2'h0);
    end
    c = crc(rs);
    if (serial_link_in) rs = {rs, c[15:8], c[7:0]};
    if (bad == 0) exp_q = {exp_q, rs};
    len_q.push_back(bad == 0 ? rs.size() : 0);
    u_mb_master.send(rq);
    n = 0;
    while (len_q.size() != 0 && n < 3000) begin
      @(posedge clock_in);
      n++;
    end
    if (n == 3000) mismatches++;
    if (n == 3000) end_of_test();
    @(negedge clock_in);
  endtask
  // Compares each reply byte, length, drop and mode against the oldest note.
  always @(posedge clock_in) begin
    if (!srst_in && tx_valid_out && tx_ready_in) begin
      cmp(tx_byte_out, exp_q.pop_front());
      pos++;
      if (tx_last_out) begin
        cmp(pos, len_q.pop_front());
        pos = 0;
      end
    end
    if (!srst_in && discard_out) cmp(0, len_q.pop_front());
    if (!srst_in && mode_strobe_out) cmp(mode_out, mode_q.pop_front());
  end
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  initial begin
    {srst_in, serial_link_in, big_endian_in, mode_busy_in, stall} = 5'b11000;
    slave_id_in = 8'h2D;
    void'($urandom(54572));
    repeat (3) @(negedge clock_in);
    srst_in = 1'b0;
    run(`FC_READ, 16'h010A, 16'h0002, 0, 0, 0);
    big_endian_in = 1'b1;
    run(`FC_READ, 16'h0100, 16'h007C, 0, 0, 0);
    foreach (vals[i]) run(`FC_READ, 16'h0100, 16'(i * 63), 0, `EXC_VALUE, 0);
    run(`FC_READ, 16'h0178, 16'h000A, 0, `EXC_ADDR, 0);
    run(8'h04, 16'h0100, 16'h0002, 0, `EXC_FUNC, 0);
    run(8'h06, 16'h0100, 16'h0002, 0, `EXC_FUNC, 0);
    for (int e = 0; e < 2; e++) begin
      big_endian_in = e[0];
      foreach (vals[i]) run(`FC_WRITE, `WR_REG, `WR_COUNT, vals[i], 0, 0);
    end
    run(`FC_WRITE, 16'h01AC, `WR_COUNT, `VAL_ZERO, `EXC_ADDR, 0);
    run(`FC_WRITE, `WR_REG, 16'h0004, `VAL_ZERO, `EXC_VALUE, 0);
    run(`FC_WRITE, `WR_REG, `WR_COUNT, 32'h4080_0000, `EXC_VALUE, 0);
    mode_busy_in = 1'b1;
    run(`FC_WRITE, `WR_REG, `WR_COUNT, `VAL_SPAN, `EXC_FAIL, 0);
    mode_busy_in = 1'b0;
    run(`FC_READ, 16'h0100, 16'h0002, 0, 0, 1);
    run(`FC_WRITE, `WR_REG, `WR_COUNT, `VAL_SPAN, 0, 2);
    serial_link_in = 1'b0;
    run(`FC_READ, 16'h0104, 16'h0004, 0, 0, 0);
    run(`FC_WRITE, `WR_REG, `WR_COUNT, `VAL_CYCLE, 0, 0);
    stall = 1'b1;
    repeat (8) begin
      serial_link_in = 1'($urandom_range(0, 1));
      big_endian_in = 1'($urandom_range(0, 1));
      slave_id_in = 8'($urandom_range(1, 247));
      r = $urandom_range(0, 40);
      run(`FC_READ, 16'(256 + 2 * r), 16'(2 * $urandom_range(1, 20)), 0, 0, 0);
    end
    end_of_test();
  end
endmodule
